/* hw/pmfs_pkg.sv */
// package: constants and carriers for the port measurement function sequencer
package pmfs_pkg;
	// ************************************************************
	// function codes
	// ************************************************************
	localparam logic [3:0] FN_DISABLE  = 4'h0;
	localparam logic [3:0] FN_DISC1    = 4'h1;
	localparam logic [3:0] FN_DISC2    = 4'h2;
	localparam logic [3:0] FN_VSAMPLE  = 4'h3;
	localparam logic [3:0] FN_CLASSIFY = 4'h4;
	localparam logic [3:0] FN_LEGACY   = 4'h5;
	localparam logic [3:0] FN_CURRENT_SAMPLE_FUNCTION  = 4'h6;

	// ************************************************************
	// probe levels applied to the port
	// ************************************************************
	localparam logic [2:0] LVL_OFF    = 3'h0;
	localparam logic [2:0] LVL_DISC1  = 3'h1; // 4.4 V below positive line
	localparam logic [2:0] LVL_DISC2  = 3'h2; // 8.8 V below positive line
	localparam logic [2:0] LVL_CLASS  = 3'h3; // 17.5 V regulated
	localparam logic [2:0] LVL_LEGACY = 3'h4; // 3.5 mA source, 20 V clamp

	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [3:0] ADDR_FUNC   = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h1;
	localparam logic [3:0] ADDR_DISC_I = 4'h2;
	localparam logic [3:0] ADDR_PORT_I = 4'h3;
	localparam logic [3:0] ADDR_VOLT   = 4'h4;
	localparam int         ADC_W       = 15;
	localparam logic [ADC_W-1:0] RESULT_RST = 15'h0000;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_MHZ     = 125;
	localparam int SETTLE_US   = 5000;
	localparam int INTEG_US    = 18000;
	localparam int PRECH_US    = 500;
	localparam int DISCH_US    = 1000;
	localparam int SETTLE_CYC  = SETTLE_US * CLK_MHZ;
	localparam int INTEG_CYC   = INTEG_US * CLK_MHZ;
	localparam int PRECH_CYC   = PRECH_US * CLK_MHZ;
	localparam int DISCH_CYC   = DISCH_US * CLK_MHZ;
	localparam int CNT_W       = 24;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_SETTLE = 3'b001,
		ST_PRECH  = 3'b010,
		ST_CHARGE = 3'b011,
		ST_COARSE = 3'b100,
		ST_FINE   = 3'b101,
		ST_STORE  = 3'b110
	} pmfs_state_t;

	typedef struct packed {
		logic       busy;
		logic       done;
		logic [2:0] phase;
		logic [2:0] level;
	} pmfs_stat_t;
endpackage : pmfs_pkg

/* hw/pmfs_adc.sv */
// integrating converter sequencer: precharge, charge, coarse and fine phases
`timescale 1ns/1ps
`default_nettype none
module pmfs_adc #(
	parameter int PRECH = pmfs_pkg::PRECH_CYC,
	parameter int INTEG = pmfs_pkg::INTEG_CYC,
	parameter int DISCH = pmfs_pkg::DISCH_CYC
) (
	input  wire logic                      CLK,
	input  wire logic                      RST,
	input  wire logic                      start,
	input  wire logic                      abort,
	input  wire logic                      sample,
	output logic [pmfs_pkg::ADC_W-1:0]     result,
	output logic                           done,
	output pmfs_pkg::pmfs_state_t          phase
);
	import pmfs_pkg::*;

	logic [CNT_W-1:0] cnt_reg;
	logic [ADC_W-1:0] acc_reg;
	logic             last;

	assign last = (cnt_reg == '0);

	// phases always run in this fixed order
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			phase   <= ST_IDLE;
			cnt_reg <= '0;
			done    <= 1'b0;
		end else begin
			done <= 1'b0;
			if (abort) begin
				phase <= ST_IDLE;
			end else begin
				if (!last)
					cnt_reg <= cnt_reg - 1'b1;
				unique case (phase)
					ST_IDLE: if (start) begin
						phase   <= ST_PRECH;
						cnt_reg <= CNT_W'(PRECH - 1);
					end
					ST_PRECH: if (last) begin
						phase   <= ST_CHARGE;
						cnt_reg <= CNT_W'(INTEG - 1);
					end
					ST_CHARGE: if (last) begin
						phase   <= ST_COARSE;
						cnt_reg <= CNT_W'(DISCH - 1);
					end
					ST_COARSE: if (last) begin
						phase   <= ST_FINE;
						cnt_reg <= CNT_W'(DISCH - 1);
					end
					ST_FINE: if (last) begin
						phase <= ST_IDLE;
						done  <= 1'b1;
					end
					default: phase <= ST_IDLE;
				endcase
			end
		end
	end

	// counts accumulate only while charging the integrator
	always_ff @(posedge CLK or posedge RST) begin
		if (RST)
			acc_reg <= RESULT_RST;
		else if (start && phase == ST_IDLE)
			acc_reg <= RESULT_RST;
		else if (phase == ST_CHARGE && sample && acc_reg != '1)
			acc_reg <= acc_reg + 1'b1;
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST)
			result <= RESULT_RST;
		else if (phase == ST_FINE && last)
			result <= acc_reg;
	end
endmodule : pmfs_adc
`default_nettype wire

/* hw/pmfs_top.sv */
// per-port measurement function sequencer for host-managed mode
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module pmfs_top #(
	parameter int SETTLE = pmfs_pkg::SETTLE_CYC,
	parameter int PRECH  = pmfs_pkg::PRECH_CYC,
	parameter int INTEG  = pmfs_pkg::INTEG_CYC,
	parameter int DISCH  = pmfs_pkg::DISCH_CYC
) (
	input  wire logic                          CLK,
	input  wire logic                          RST,
	input  wire logic [3:0]                    ADDR,
	input  wire logic [15:0]                   WDATA,
	input  wire logic                          WR,
	input  wire logic                          RD,
	output logic [15:0]                        RDATA,
	input  wire logic                          ADC_PULSE,
	output logic [2:0]                         PROBE_LEVEL,
	output logic                               CLAMP_20V,
	output logic                               DONE
);
	import pmfs_pkg::*;

	// ************************************************************
	// state
	// ************************************************************
	pmfs_state_t      state_reg;
	pmfs_state_t      adc_phase;
	logic [3:0]       func_reg;
	logic [CNT_W-1:0] settle_reg;
	logic [ADC_W-1:0] disc_i_reg;
	logic [ADC_W-1:0] port_i_reg;
	logic [ADC_W-1:0] volt_reg;
	logic [ADC_W-1:0] adc_result;
	logic             adc_done;
	logic             adc_start;
	logic             call;
	logic             measuring;
	logic             pulse_s1;
	logic             pulse_s2;
	pmfs_stat_t       stat;

	// comparator output from the analog side is asynchronous
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			pulse_s1 <= 1'b0;
			pulse_s2 <= 1'b0;
		end else begin
			pulse_s1 <= ADC_PULSE;
			pulse_s2 <= pulse_s1;
		end
	end

	assign call = WR && ADDR == ADDR_FUNC;
	assign measuring = WDATA[3:0] == FN_DISC1 || WDATA[3:0] == FN_DISC2
		|| WDATA[3:0] == FN_CLASSIFY || WDATA[3:0] == FN_LEGACY
		|| WDATA[3:0] == FN_CURRENT_SAMPLE_FUNCTION || WDATA[3:0] == FN_VSAMPLE;
	assign adc_start = state_reg == ST_SETTLE && settle_reg == '0;

	// ************************************************************
	// converter
	// ************************************************************
	pmfs_adc #(
		.PRECH (PRECH),
		.INTEG (INTEG),
		.DISCH (DISCH)
	) u_adc (
		.CLK    (CLK),
		.RST    (RST),
		.start  (adc_start),
		.abort  (call),
		.sample (pulse_s2),
		.result (adc_result),
		.done   (adc_done),
		.phase  (adc_phase)
	);

	// ************************************************************
	// function sequencer
	// ************************************************************
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			state_reg  <= ST_IDLE;
			func_reg   <= FN_DISABLE;
			settle_reg <= '0;
		end else if (call) begin
			// a new call aborts whatever is running
			func_reg <= WDATA[3:0];
			if (measuring) begin
				state_reg  <= ST_SETTLE;
				settle_reg <= CNT_W'(SETTLE - 1);
			end else begin
				state_reg <= ST_IDLE;
			end
		end else begin
			unique case (state_reg)
				ST_SETTLE: begin
					if (settle_reg != '0)
						settle_reg <= settle_reg - 1'b1;
					else
						state_reg <= ST_CHARGE;
				end
				ST_CHARGE: if (adc_done)
					state_reg <= ST_STORE;
				ST_STORE: state_reg <= ST_IDLE;
				ST_IDLE: state_reg <= ST_IDLE;
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// ************************************************************
	// probe level: held after measuring until next call
	// ************************************************************
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			PROBE_LEVEL <= LVL_OFF;
			CLAMP_20V   <= 1'b0;
		end else if (call) begin
			CLAMP_20V <= WDATA[3:0] == FN_LEGACY;
			unique case (WDATA[3:0])
				FN_DISC1:    PROBE_LEVEL <= LVL_DISC1;
				FN_DISC2:    PROBE_LEVEL <= LVL_DISC2;
				FN_CLASSIFY: PROBE_LEVEL <= LVL_CLASS;
				FN_LEGACY:   PROBE_LEVEL <= LVL_LEGACY;
				default:     PROBE_LEVEL <= LVL_OFF;
			endcase
		end
	end

	// ************************************************************
	// result registers: overwritten only by their own functions
	// ************************************************************
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			disc_i_reg <= RESULT_RST;
			port_i_reg <= RESULT_RST;
			volt_reg   <= RESULT_RST;
		end else if (state_reg == ST_CHARGE && adc_done) begin
			unique case (func_reg)
				FN_DISC1, FN_DISC2:
					disc_i_reg <= adc_result;
				FN_CLASSIFY, FN_CURRENT_SAMPLE_FUNCTION:
					port_i_reg <= adc_result;
				FN_LEGACY, FN_VSAMPLE:
					volt_reg <= adc_result;
				default: ;
			endcase
		end
	end

	// done follows the stored result by one cycle
	always_ff @(posedge CLK or posedge RST) begin
		if (RST)
			DONE <= 1'b0;
		else if (call)
			DONE <= !measuring;
		else if (state_reg == ST_STORE)
			DONE <= 1'b1;
	end

	// ************************************************************
	// register read port
	// ************************************************************
	assign stat = '{busy: state_reg != ST_IDLE, done: DONE,
		phase: adc_phase, level: PROBE_LEVEL};

	always_ff @(posedge CLK or posedge RST) begin
		if (RST)
			RDATA <= 16'h0000;
		else if (RD) begin
			unique case (ADDR)
				ADDR_FUNC:   RDATA <= {12'h000, func_reg};
				ADDR_STATUS: RDATA <= {8'h00, stat};
				ADDR_DISC_I: RDATA <= {1'b0, disc_i_reg};
				ADDR_PORT_I: RDATA <= {1'b0, port_i_reg};
				ADDR_VOLT:   RDATA <= {1'b0, volt_reg};
				default:     RDATA <= 16'h0000;
			endcase
		end else
			RDATA <= 16'h0000;
	end

	// ************************************************************
	// checks
	// ************************************************************
	done_after_store_a: assert property (@(posedge CLK) disable iff (RST)
		state_reg == ST_STORE && !call |=> DONE)
		else $error("done not set after store");
	done_clear_a: assert property (@(posedge CLK) disable iff (RST)
		call && measuring |=> !DONE)
		else $error("done not cleared on call");
	disable_done_a: assert property (@(posedge CLK) disable iff (RST)
		call && WDATA[3:0] == FN_DISABLE |=> DONE && PROBE_LEVEL == LVL_OFF)
		else $error("disable did not finish");
	disc1_level_a: assert property (@(posedge CLK) disable iff (RST)
		call && WDATA[3:0] == FN_DISC1 |=> PROBE_LEVEL == LVL_DISC1)
		else $error("disc1 level wrong");
	level_hold_a: assert property (@(posedge CLK) disable iff (RST)
		!call |=> $stable(PROBE_LEVEL))
		else $error("level moved without call");
	disc_keep_a: assert property (@(posedge CLK) disable iff (RST)
		!(state_reg == ST_CHARGE && adc_done && (func_reg == FN_DISC1
		|| func_reg == FN_DISC2)) |=> $stable(disc_i_reg))
		else $error("discovery result changed");
	port_keep_a: assert property (@(posedge CLK) disable iff (RST)
		!(state_reg == ST_CHARGE && adc_done) |=> $stable(port_i_reg))
		else $error("port current changed");
	clamp_legacy_a: assert property (@(posedge CLK) disable iff (RST)
		PROBE_LEVEL == LVL_LEGACY |-> CLAMP_20V)
		else $error("legacy without clamp");
endmodule : pmfs_top
`default_nettype wire

/* sim/pmfs_pd_model.sv */
// powered device model: drives the comparator pulse for each probe level
`timescale 1ns/1ps
`default_nettype none
module pmfs_pd_model (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [2:0] level,
	output logic            pulse
);
	import pmfs_pkg::*;
	logic toggle_reg;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			toggle_reg <= 1'b0;
		end else begin
			toggle_reg <= ~toggle_reg;
		end
	end

	// idle port chatters so that stale counts cannot pass unseen
	always_comb begin
		case (level)
			LVL_OFF:   pulse = toggle_reg;
			LVL_DISC2: pulse = toggle_reg;
			default:   pulse = 1'b1;
		endcase
	end
endmodule : pmfs_pd_model
`default_nettype wire

/* sim/tb_top.sv */
// self-checking bench for the port measurement function sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import pmfs_pkg::*;
	localparam int P_SET = 4;
	localparam int P_PRE = 2;
	localparam int P_INT = 8;
	localparam int P_DIS = 2;
	logic        clk;
	logic        rst;
	logic [3:0]  addr;
	logic [15:0] wdata;
	logic        wr;
	logic        rd;
	logic [15:0] rdata;
	logic        adc_pulse;
	logic [2:0]  probe_level;
	logic        clamp_20v;
	logic        done;
	logic        rd_d;
	logic [15:0] lfsr;
	logic [15:0] exp_q[$];
	int          miscompares;
	int          checked;
	int          cycles;
	int          n;

	pmfs_top #(.SETTLE(P_SET), .PRECH(P_PRE), .INTEG(P_INT), .DISCH(P_DIS))
	DUT (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
		.RD(rd), .RDATA(rdata), .ADC_PULSE(adc_pulse),
		.PROBE_LEVEL(probe_level), .CLAMP_20V(clamp_20v), .DONE(done));

	pmfs_pd_model pd (.clk(clk), .rst(rst), .level(probe_level),
		.pulse(adc_pulse));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ************************************************************
	// helpers
	// ************************************************************
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr_next

	task automatic report_and_stop;
		$display("checks %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input string what, input logic [15:0] e,
		input logic [15:0] g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask : chk

	// leading edge wait keeps strobe release and next request apart
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk);
		rd   <= 1'b0;
	endtask : rd_reg

	task automatic call_fn(input logic [3:0] code, input logic [2:0] lvl,
		input logic exp_done, output int cnt);
		wr_reg(ADDR_FUNC, {12'h000, code});
		#1;
		chk("probe_level", {13'h0, lvl}, {13'h0, probe_level});
		chk("done_on_call", {15'h0, exp_done}, {15'h0, done});
		cnt = 0;
		while (done !== 1'b1 && cnt < 200) begin
			@(posedge clk);
			#1;
			cnt++;
		end
	endtask : call_fn

	task automatic measure(input logic [3:0] code, input logic [2:0] lvl,
		input logic [3:0] a, input logic [15:0] e);
		int c;
		call_fn(code, lvl, 1'b0, c);
		chk("duration", 16'h0001, {15'h0, c >= P_SET + P_INT && c <= 40});
		repeat (5) @(posedge clk);
		#1;
		chk("level_held", {13'h0, lvl}, {13'h0, probe_level});
		chk("clamp", {15'h0, lvl == LVL_LEGACY}, {15'h0, clamp_20v});
		rd_reg(a, e);
		// idle, done, converter idle, level still applied
		rd_reg(ADDR_STATUS, {8'h00, 2'b01, 3'b000, lvl});
		rd_reg(ADDR_FUNC, {12'h000, code});
		$display("test function %h done", code);
	endtask : measure

	// ************************************************************
	// read data monitor and timeout
	// ************************************************************
	always @(posedge clk) begin
		if (rd_d && exp_q.size() > 0) begin
			chk("rdata", exp_q.pop_front(), rdata);
		end
		rd_d <= rd;
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			report_and_stop;
		end
	end

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		rst = 1'b1;
		addr = 4'h0;
		wdata = 16'h0000;
		wr = 1'b0;
		rd = 1'b0;
		rd_d = 1'b0;
		lfsr = 16'hf940;
		miscompares = 0;
		checked = 0;
		cycles = 0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rd_reg(ADDR_DISC_I, {1'b0, RESULT_RST});
		rd_reg(ADDR_PORT_I, {1'b0, RESULT_RST});
		rd_reg(ADDR_VOLT, {1'b0, RESULT_RST});
		$display("test reset done");
		measure(FN_DISC1, LVL_DISC1, ADDR_DISC_I, P_INT);
		measure(FN_DISC2, LVL_DISC2, ADDR_DISC_I, P_INT / 2);
		// a single port only ever classifies here
		measure(FN_CLASSIFY, LVL_CLASS, ADDR_PORT_I, P_INT);
		rd_reg(ADDR_DISC_I, P_INT / 2);
		measure(FN_LEGACY, LVL_LEGACY, ADDR_VOLT, P_INT);
		rd_reg(ADDR_PORT_I, P_INT);
		// idle port chatters: half the charge cycles count
		measure(FN_CURRENT_SAMPLE_FUNCTION, LVL_OFF, ADDR_PORT_I, P_INT / 2);
		measure(FN_VSAMPLE, LVL_OFF, ADDR_VOLT, P_INT / 2);
		wr_reg(ADDR_FUNC, {12'h000, FN_LEGACY});
		repeat (3) @(posedge clk);
		call_fn(FN_DISABLE, LVL_OFF, 1'b1, n);
		chk("disable_clamp", 16'h0000, {15'h0, clamp_20v});
		$display("test abort done");
		for (int i = 0; i < 4; i++) begin
			lfsr = lfsr_next(lfsr);
			wr_reg({1'b1, lfsr[2:0]}, lfsr);
			rd_reg({1'b1, lfsr[2:0]}, 16'h0000);
		end
		rd_reg(ADDR_FUNC, {12'h000, FN_DISABLE});
		#1;
		chk("unmapped_level", 16'h0000, {13'h0, probe_level});
		repeat (3) @(posedge clk);
		$display("test unmapped done");
		report_and_stop;
	end
endmodule : tb_top
`default_nettype wire
